// File: core/rcl_core.sv
/*
  remote control command logic: remote inputs acting as panel buttons,
  amplifier inhibit, level select, raise/lower ramp, open-collector status.
  assumes remote inputs are asynchronous to i_ref_clk and that an
  APB master on the same clock reaches the registers.
*/
// Design decisions made here: the register offsets and the APB slave port.
// Operation
// R1: remote input acts like matching panel button
// R2: status sinks low while matching indicator lit
// R3: off command switches amplifier supply off
// R4: inhibit holds amplifier modules off, zero RF
// R5: inhibit release restores previous power level
// R6: inhibit keeps supply on, no red fault
// R7: inhibit lights diagnostic segment nine red
// R8: qualified level pulse turns on at level
// R9: level pulse while on changes level seamlessly
// R10: raise ramps power up until limit
// R11: lower ramps power down until zero
// R12: inhibit input is not a safety interlock
// R13: inputs synchronized, debounced, short pulses ignored
`timescale 1ns/1ps
`include "rcl_map.svh"
module rcl_core #(
  parameter int SEL_MIN_CYC = `RCL_SEL_MIN_CYC,
  parameter int RAMP_CYC = `RCL_RAMP_CYC,
  parameter int DEB_CYC = `RCL_DEB_CYC
) (
  input wire logic i_ref_clk, // system clock 20 MHz
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_rem_off, // remote off command
  input wire logic i_rem_inhibit, // remote amplifier inhibit
  input wire logic i_rem_low, // remote low level select
  input wire logic i_rem_med, // remote medium level select
  input wire logic i_rem_high, // remote high level select
  input wire logic i_rem_raise, // remote raise
  input wire logic i_rem_lower, // remote lower
  input wire logic i_fault_lit, // local fault indicator lit
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  output logic o_pa_supply_on, // amplifier supply enable
  output logic o_mod_enable, // modulator drive to amplifier modules
  output logic [7:0] o_power_level, // power setpoint to modulator
  output logic o_seg9_red, // diagnostic display segment nine
  output logic o_stat_on_n, // status sink: transmitter on
  output logic o_stat_inh_n, // status sink: inhibit active
  output logic o_stat_fault_n, // status sink: fault lit
  output rcl_pkg::rcl_lvl_t o_level // selected level
);
  import rcl_pkg::*;

  localparam int NIN = 7;
  localparam int CW = 22;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  // both stages clear at once when the pin drops; release ripples
  // through two edges, so no flop leaves reset on a marginal edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  // every other process resets from this copy only
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // input synchronizer and debounce
  // ----------------------------------------
  // three stages; a change counts once stages two and three agree
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_r, s2_r, s3_r;
  logic [NIN-1:0] deb_r;
  // one counter per input, so a bouncing line never stalls the others
  logic [CW-1:0] deb_cnt_r [NIN];
  assign raw = {i_rem_lower, i_rem_raise, i_rem_high, i_rem_med, i_rem_low,
                i_rem_inhibit, i_rem_off};
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a level must stand stable for DEB_CYC before it is accepted
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_r <= '0;
      for (int i = 0; i < NIN; i++) deb_cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (s2_r[i] != s3_r[i] || s3_r[i] == deb_r[i]) begin
          deb_cnt_r[i] <= '0;
        end else if (deb_cnt_r[i] >= CW'(DEB_CYC - 1)) begin
          deb_r[i] <= s3_r[i]; // R13
          deb_cnt_r[i] <= '0;
        end else begin
          deb_cnt_r[i] <= deb_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic local_inh_r;
  logic [7:0] limit_r;
  logic [7:0] preset_r [3];
  logic apb_wr, apb_rd;
  // writes land at the access edge; read data is launched at the setup edge,
  // so neither direction needs a wait state
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && !i_penable && !i_pwrite;

  // local inhibit switch and power limit are software-set
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_inh_r <= 1'b0;
      limit_r <= `RCL_LIMIT_RST;
    end else if (apb_wr) begin
      if (i_paddr == `RCL_OFS_CTRL) local_inh_r <= i_pwdata[`RCL_CTRL_LOCAL_INH];
      if (i_paddr == `RCL_OFS_LIMIT) limit_r <= i_pwdata[7:0];
    end
  end

  // ----------------------------------------
  // level select qualification
  // ----------------------------------------
  logic [CW-1:0] sel_cnt_r;
  logic sel_fired_r;
  logic sel_pulse;
  logic [2:0] sel_in;
  logic [2:0] sel_lvl_r;
  assign sel_in = deb_r[4:2];
  // one select must be held SEL_MIN_CYC; shorter pulses are dropped
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_cnt_r <= '0;
      sel_fired_r <= 1'b0;
      sel_lvl_r <= 3'b000;
    end else if (sel_in == 3'b000 || sel_in != sel_lvl_r) begin
      sel_cnt_r <= '0;
      sel_fired_r <= 1'b0;
      sel_lvl_r <= sel_in;
    end else if (!sel_fired_r && sel_cnt_r >= CW'(SEL_MIN_CYC - 1)) begin
      sel_fired_r <= 1'b1; // R8 R13
    end else if (!sel_fired_r) begin
      sel_cnt_r <= sel_cnt_r + 1'b1;
    end
  end
  // single-cycle strike on the edge that sets sel_fired_r; two selects at once
  // fail the one-hot test, so a crossed contact pair is ignored
  assign sel_pulse = !sel_fired_r && sel_in != 3'b000 && sel_in == sel_lvl_r
                     && (sel_in == 3'b001 || sel_in == 3'b010 || sel_in == 3'b100)
                     && sel_cnt_r >= CW'(SEL_MIN_CYC - 1);

  // one-hot level to preset slot; an illegal code takes the slot of its highest set bit, zero falls to the low slot
  function automatic logic [1:0] lvl_idx(input logic [2:0] l);
    lvl_idx = l[2] ? 2'h2 : (l[1] ? 2'h1 : 2'h0);
  endfunction

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  rcl_state_t state_r;
  rcl_lvl_t level_r;
  // the level follows a select only on its qualifying edge, never while held
  // off wins over a simultaneous select, like the panel off button
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RCL_ST_OFF;
      level_r <= RCL_LVL_LOW;
    end else begin
      case (state_r)
        RCL_ST_OFF: begin
          if (!deb_r[0] && sel_pulse) begin
            state_r <= RCL_ST_ON; // R8
            level_r <= rcl_lvl_t'(sel_in);
          end
        end
        RCL_ST_ON: begin
          if (deb_r[0]) begin
            state_r <= RCL_ST_OFF; // R1 R3
          end else if (sel_pulse) begin
            level_r <= rcl_lvl_t'(sel_in); // R9
          end
        end
        default: state_r <= RCL_ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // raise / lower ramp of the level presets
  // ----------------------------------------
  logic [CW-1:0] ramp_cnt_r;
  logic ramp_tick;
  logic [1:0] cur_idx;
  // preset slot of the level in use
  assign cur_idx = lvl_idx(level_r);
  // step timer runs only while exactly one of raise and lower is held
  assign ramp_tick = ramp_cnt_r >= CW'(RAMP_CYC - 1);
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_cnt_r <= '0;
    end else if (ramp_tick || deb_r[5] == deb_r[6]) begin
      ramp_cnt_r <= '0;
    end else begin
      ramp_cnt_r <= ramp_cnt_r + 1'b1;
    end
  end
  // presets are remembered per level, so each select returns to its own set power
  // limitation: a lowered limit pulls a preset down only on a step edge, so a
  // limit write alone leaves the preset above it until raise or lower is used
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_r[0] <= `RCL_PRESET_LOW_RST;
      preset_r[1] <= `RCL_PRESET_MED_RST;
      preset_r[2] <= `RCL_PRESET_HIGH_RST;
    end else if (state_r == RCL_ST_ON && ramp_tick) begin
      if (deb_r[5] && preset_r[cur_idx] < limit_r) begin
        preset_r[cur_idx] <= preset_r[cur_idx] + 8'h01; // R10
      end else if (deb_r[6] && preset_r[cur_idx] != 8'h00) begin
        preset_r[cur_idx] <= preset_r[cur_idx] - 8'h01; // R11
      end else if (preset_r[cur_idx] > limit_r) begin
        preset_r[cur_idx] <= limit_r;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic inh_any;
  logic is_on;
  // the inhibit only gates modulator drive and the setpoint output; the preset is untouched, and
  // it is not a safety path: RF returns as soon as it drops
  assign inh_any = deb_r[1] || local_inh_r; // R1 R12
  assign is_on = state_r == RCL_ST_ON;
  // all outputs registered, so the terminal strips never see a decode glitch
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pa_supply_on <= 1'b0;
      o_mod_enable <= 1'b0;
      o_power_level <= 8'h00;
      o_seg9_red <= 1'b0;
      o_stat_on_n <= 1'b1;
      o_stat_inh_n <= 1'b1;
      o_stat_fault_n <= 1'b1;
      o_level <= RCL_LVL_LOW;
    end else begin
      o_pa_supply_on <= is_on; // R3 R6
      o_mod_enable <= is_on && !inh_any; // R4 R5
      o_power_level <= (is_on && !inh_any) ? preset_r[cur_idx] : 8'h00; // R4 R5
      o_seg9_red <= inh_any; // R7
      o_stat_on_n <= !is_on; // R2
      o_stat_inh_n <= !inh_any; // R2
      o_stat_fault_n <= !i_fault_lit; // R2 R6
      o_level <= level_r;
    end
  end

  // ----------------------------------------
  // apb slave: zero wait states, error on unmapped
  // ----------------------------------------
  // only the four word offsets answer without an error
  logic mapped;
  assign mapped = i_paddr == `RCL_OFS_CTRL || i_paddr == `RCL_OFS_STAT
                  || i_paddr == `RCL_OFS_LEVEL || i_paddr == `RCL_OFS_LIMIT;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      // status bit two is the segment output as it stood a cycle earlier
      if (apb_rd) begin
        case (i_paddr)
          `RCL_OFS_CTRL: o_prdata <= {31'h0, local_inh_r};
          `RCL_OFS_STAT: o_prdata <= {20'h00000, preset_r[cur_idx], 1'b0, o_seg9_red,
                                      inh_any, is_on};
          `RCL_OFS_LEVEL: o_prdata <= {29'h0, level_r};
          `RCL_OFS_LIMIT: o_prdata <= {24'h0, limit_r};
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: core/rcl_map.svh
/*
  constants of the remote control command logic: register offsets,
  reset values and timing counts.
  assumes a 20 MHz reference clock and an APB slave with 32-bit data.
*/
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RCL_OFS_CTRL 12'h000
`define RCL_OFS_STAT 12'h004
`define RCL_OFS_LEVEL 12'h008
`define RCL_OFS_LIMIT 12'h00C
// ----------------------------------------
// field positions
// ----------------------------------------
`define RCL_CTRL_LOCAL_INH 0
`define RCL_STAT_ON 0
`define RCL_STAT_INH 1
`define RCL_STAT_SEG9 2
`define RCL_STAT_PRESET_LSB 4
// ----------------------------------------
// reset values
// ----------------------------------------
`define RCL_LIMIT_RST 8'hFF
`define RCL_PRESET_LOW_RST 8'h40
`define RCL_PRESET_MED_RST 8'h80
`define RCL_PRESET_HIGH_RST 8'hC0
// ----------------------------------------
// timing
// ----------------------------------------
`define RCL_CLK_HZ 20000000
`define RCL_SEL_MIN_MS 100
`define RCL_SEL_MIN_CYC ((`RCL_CLK_HZ / 1000) * `RCL_SEL_MIN_MS)
`define RCL_DEB_US 1
`define RCL_DEB_CYC ((`RCL_CLK_HZ / 1000000) * `RCL_DEB_US)
`define RCL_RAMP_MS 10
`define RCL_RAMP_CYC ((`RCL_CLK_HZ / 1000) * `RCL_RAMP_MS)
`endif

// File: core/rcl_pkg.sv
/*
  types of the remote control command logic.
  assumes rcl_map.svh is on the include path.
*/
package rcl_pkg;
  // power level selected by the operator
  typedef enum logic [2:0] {
    RCL_LVL_LOW = 3'b001,
    RCL_LVL_MED = 3'b010,
    RCL_LVL_HIGH = 3'b100
  } rcl_lvl_t;
  // transmitter power state
  typedef enum logic [1:0] {
    RCL_ST_OFF = 2'b01,
    RCL_ST_ON = 2'b10
  } rcl_state_t;
endpackage

// File: bench/rcl_core_sva.sv
/*
  checker on the ports of rcl_core.
  assumes one clock domain and shortened counts (debounce of 2).
*/
`timescale 1ns/1ps
module rcl_core_sva (
  input wire logic i_ref_clk, // clock
  input wire logic i_reset_n, // reset
  input wire logic i_rem_off, // off
  input wire logic i_fault_lit, // fault lamp
  input wire logic i_psel, // apb
  input wire logic i_penable, // apb
  input wire logic o_pready, // apb
  input wire logic o_pa_supply_on, // supply
  input wire logic o_mod_enable, // modulator
  input wire logic [7:0] o_power_level, // setpoint
  input wire logic o_seg9_red, // segment nine
  input wire logic o_stat_on_n, // sink on
  input wire logic o_stat_fault_n, // sink fault
  input wire rcl_pkg::rcl_lvl_t o_level // level
);
  import rcl_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  property p_pready; i_psel && !i_penable |=> o_pready; endproperty
  property p_seg9_zero; o_seg9_red |-> !o_mod_enable && o_power_level == 8'h00; endproperty
  property p_inh_supply; $rose(o_seg9_red) |-> $stable(o_pa_supply_on); endproperty
  property p_inh_return; $fell(o_seg9_red) && o_pa_supply_on |-> ##[0:1] o_mod_enable;
  endproperty
  property p_fault_sink; i_fault_lit ##1 i_fault_lit |-> !o_stat_fault_n; endproperty
  property p_stat_on; o_pa_supply_on ##1 o_pa_supply_on |-> !o_stat_on_n; endproperty
  // synchroniser plus debounce fits inside eight held cycles
  property p_off_kills; i_rem_off [*8] |=> !o_pa_supply_on; endproperty
  property p_onehot; $onehot(o_level); endproperty
  a_pready: assert property (p_pready) else $error("no ready after setup");
  a_seg9_zero: assert property (p_seg9_zero) else $error("rf while inhibited");
  a_inh_supply: assert property (p_inh_supply) else $error("inhibit moved supply");
  a_inh_return: assert property (p_inh_return) else $error("no return after inhibit");
  a_fault_sink: assert property (p_fault_sink) else $error("fault sink missing");
  a_stat_on: assert property (p_stat_on) else $error("on sink missing");
  a_off_kills: assert property (p_off_kills) else $error("off ignored");
  a_onehot: assert property (p_onehot) else $error("level not one-hot");
  c_inh: cover property (o_mod_enable ##1 o_seg9_red);
  c_on: cover property ($rose(o_pa_supply_on));
  c_off: cover property ($fell(o_pa_supply_on));
endmodule
bind rcl_core rcl_core_sva i_sva (.i_ref_clk, .i_reset_n, .i_rem_off, .i_fault_lit, .i_psel,
  .i_penable, .o_pready, .o_pa_supply_on, .o_mod_enable, .o_power_level, .o_seg9_red,
  .o_stat_on_n, .o_stat_fault_n, .o_level);

// File: bench/rcl_remote_model.sv
/*
  remote control system: contact closures on the remote inputs.
  assumes the bench calls press; bits are off, inhibit, low, med, high, raise, lower.
*/
`timescale 1ns/1ps
module rcl_remote_model (
  input wire logic i_clk, // clock
  output logic [6:0] o_cmd // closures
);
  initial o_cmd = 7'h00;
  // ----------------------------------------
  // one closure held for n cycles
  // ----------------------------------------
  // selects are held past the minimum unless a short pulse is wanted
  // inhibit only used for switching, never as an interlock
  task automatic press(input int k, input int n);
    @(posedge i_clk);
    o_cmd[k] <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_cmd[k] <= 1'b0;
  endtask
endmodule

// File: bench/tb.sv
/*
  testbench of rcl_core: apb tasks and remote closures.
  assumes shortened counts: select 50, ramp 8, debounce 2.
*/
`timescale 1ns/1ps
`include "rcl_map.svh"
module tb;
  import rcl_pkg::*;
  localparam int K_OFF = 0, K_INH = 1, K_LOW = 2, K_MED = 3, K_HIGH = 4, K_UP = 5, K_DN = 6;
  logic clk = 1'b0, rst_n = 1'b0, fault = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, er, supply, mod_en, seg9, on_n, inh_n, fault_n, drop;
  logic [7:0] power;
  logic [6:0] cmd;
  rcl_lvl_t level;
  int errors = 0, cmp_count = 0;
  wire logic [13:0] obs = {supply, mod_en, seg9, on_n, inh_n, fault_n, power};
  always #25 clk = ~clk;
  rcl_remote_model i_rem (.i_clk(clk), .o_cmd(cmd));
  rcl_core #(.SEL_MIN_CYC(50), .RAMP_CYC(8), .DEB_CYC(2)) i_dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_rem_off(cmd[K_OFF]), .i_rem_inhibit(cmd[K_INH]),
    .i_rem_low(cmd[K_LOW]), .i_rem_med(cmd[K_MED]), .i_rem_high(cmd[K_HIGH]),
    .i_rem_raise(cmd[K_UP]), .i_rem_lower(cmd[K_DN]), .i_fault_lit(fault), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_pa_supply_on(supply),
    .o_mod_enable(mod_en), .o_power_level(power), .o_seg9_red(seg9), .o_stat_on_n(on_n),
    .o_stat_inh_n(inh_n), .o_stat_fault_n(fault_n), .o_level(level));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the ~2300 cycles of the sequence
  initial begin
    #(50 * 20000);
    errors++;
    summarize();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `RCL_OFS_LIMIT, 32'h00000000);
    chk(rd, 32'h000000FF);
    apb(1'b0, `RCL_OFS_LEVEL, 32'h00000000);
    chk(rd, 32'h00000001);
    apb(1'b1, 12'h010, 32'h00000001);
    chk(er, 1'b1);
    apb(1'b0, 12'h010, 32'h00000000);
    chk({er, rd[30:0]}, 32'h80000000);
    chk(obs, {6'b000111, 8'h00});
    $display("test regs done");
    i_rem.press(K_LOW, 30);
    repeat (10) @(posedge clk);
    chk(obs, {6'b000111, 8'h00});
    i_rem.press(K_LOW, 70);
    repeat (10) @(posedge clk);
    chk(obs, {6'b110011, 8'h40});
    chk(level, RCL_LVL_LOW);
    drop = 1'b0;
    fork
      i_rem.press(K_HIGH, 70);
      repeat (80) begin
        @(posedge clk);
        if (mod_en !== 1'b1) drop = 1'b1;
      end
    join
    chk(drop, 1'b0);
    chk(obs, {6'b110011, 8'hC0});
    $display("test select done");
    apb(1'b1, `RCL_OFS_LIMIT, 32'h000000C3);
    i_rem.press(K_UP, 120);
    repeat (10) @(posedge clk);
    chk(power, 8'hC3);
    i_rem.press(K_DN, 1700);
    repeat (10) @(posedge clk);
    chk(obs, {6'b110011, 8'h00});
    i_rem.press(K_MED, 70);
    repeat (10) @(posedge clk);
    chk(obs, {6'b110011, 8'h80});
    $display("test ramp done");
    fork
      i_rem.press(K_INH, 40);
      begin
        repeat (20) @(posedge clk);
        chk(obs, {6'b101001, 8'h00});
      end
    join
    repeat (10) @(posedge clk);
    chk(obs, {6'b110011, 8'h80});
    apb(1'b1, `RCL_OFS_CTRL, 32'h00000001);
    repeat (3) @(posedge clk);
    chk(obs, {6'b101001, 8'h00});
    apb(1'b0, `RCL_OFS_STAT, 32'h00000000);
    chk(rd & 32'h00000005, 32'h00000005);
    apb(1'b1, `RCL_OFS_CTRL, 32'h00000000);
    repeat (3) @(posedge clk);
    chk(obs, {6'b110011, 8'h80});
    $display("test inhibit done");
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    chk(obs, {6'b110010, 8'h80});
    fault <= 1'b0;
    i_rem.press(K_OFF, 20);
    repeat (10) @(posedge clk);
    chk(obs, {6'b000111, 8'h00});
    $display("test off done");
    summarize();
  end
endmodule
